// [logic/dual_timer_pkg.sv]
// constants shared by the dual interval timer and its bench
package dual_timer_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [15:0] IDX_DUAL_TIMER_CONTROL = 16'hfe3c;
	localparam logic [15:0] IDX_FIRST_TIMER_PERIOD = 16'hfe3e;
	localparam logic [15:0] IDX_SECOND_TIMER_PERIOD = 16'hfe3f;
	localparam logic [15:0] IDX_EVENT_STATUS = 16'hfe40;
	localparam logic [15:0] IDX_EVENT_MASK = 16'hfe41;
	localparam logic [15:0] IDX_FIRST_TIMER_COUNTER = 16'hfe42;
	localparam logic [15:0] IDX_SECOND_TIMER_COUNTER = 16'hfe43;

	// ==========================================================
	// control register fields
	localparam int FIRST_IRQ_ENABLE_BIT = 0;
	localparam int FIRST_OVERFLOW_FLAG_BIT = 1;
	localparam int SECOND_IRQ_ENABLE_BIT = 2;
	localparam int SECOND_OVERFLOW_FLAG_BIT = 3;
	localparam int FIRST_CLOCK_SELECT_LO_BIT = 4;
	localparam int SECOND_CLOCK_SELECT_LO_BIT = 6;

	// ==========================================================
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'h00;
	localparam logic [1:0] EVENT_RESET = 2'h0;

	// ==========================================================
	// count clocks in cycle periods, and prescaler terminal counts
	localparam int COUNT_CLOCK_SEL1_TCYC = 4;
	localparam int COUNT_CLOCK_SEL2_TCYC = 16;
	localparam int COUNT_CLOCK_SEL3_TCYC = 64;
	localparam logic [5:0] PRESCALE_TERM_SEL1 = 6'(COUNT_CLOCK_SEL1_TCYC - 1);
	localparam logic [5:0] PRESCALE_TERM_SEL2 = 6'(COUNT_CLOCK_SEL2_TCYC - 1);
	localparam logic [5:0] PRESCALE_TERM_SEL3 = 6'(COUNT_CLOCK_SEL3_TCYC - 1);

	// ==========================================================
	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

endpackage : dual_timer_pkg

// [logic/dual_interval_timer_8bit.sv]
// two 8-bit interval timers with prescalers behind an AHB-Lite slave
//
// Function
// - each timer is an 8-bit counter behind its own 6-bit prescaler
// - first timer select 00 holds reset; 01/10/11 count every 4/16/64 cycles
// - second timer select 00 holds reset; 01/10/11 count every 4/16/64 cycles
// - first counter wraps to 0 after reaching its period, setting its flag
// - second counter wraps to 0 after reaching its period, setting its flag
// - timer period is (period value plus one) times the count clock
// - first select (control bits 5:4) zero stops the counter at 0
// - second select (control bits 7:6) zero stops the counter at 0
// - writing first period while running clears its prescaler and counter
// - writing second period while running clears its prescaler and counter
// - first overflow flag, control bit 1, sets once per period and sticks
// - second overflow flag, control bit 3, sets once per period and sticks
// - first enable bit 0 with its flag requests the shared vector
// - second enable bit 2 with its flag requests the shared vector
`timescale 1ns/10ps

module dual_interval_timer_8bit (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic SRST,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// interrupts
	output logic VECTOR_REQ,
	output logic IRQ
);
	import dual_timer_pkg::*;

	// ==========================================================
	// bus slave
	logic addr_take;
	logic wr_act_r;
	logic [15:0] wr_idx_r;
	logic rd_wait_r;
	logic [15:0] rd_idx_r;
	logic addr_hit;
	logic [31:0] rd_val;
	logic [31:0] hrdata_r;

	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [1:0] evt_r;
	logic [1:0] evt_nxt;
	logic [1:0] mask_r;
	logic [7:0] per_r [2];
	logic [7:0] cnt_r [2];
	logic [5:0] pre_r [2];
	logic [1:0] ovf_ev;
	logic [1:0] per_wr;

	// only whole-word accesses are expected; size is not checked
	assign addr_take = HSEL && HREADY && HTRANS[1];
	assign addr_hit = (HADDR[31:18] == 14'h0000);

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			wr_act_r <= 1'b0;
			wr_idx_r <= 16'h0000;
		end else begin
			wr_act_r <= addr_take && HWRITE && addr_hit;
			wr_idx_r <= HADDR[17:2];
		end
	end

	// reads take one wait state so the data comes from a flop after any write
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			rd_wait_r <= 1'b0;
			rd_idx_r <= 16'h0000;
		end else begin
			rd_wait_r <= addr_take && !HWRITE;
			rd_idx_r <= addr_hit ? HADDR[17:2] : 16'h0000;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (rd_idx_r)
			IDX_DUAL_TIMER_CONTROL: rd_val = {24'h000000, ctrl_r};
			IDX_FIRST_TIMER_PERIOD: rd_val = {24'h000000, per_r[0]};
			IDX_SECOND_TIMER_PERIOD: rd_val = {24'h000000, per_r[1]};
			IDX_EVENT_STATUS: rd_val = {30'h00000000, evt_r};
			IDX_EVENT_MASK: rd_val = {30'h00000000, mask_r};
			IDX_FIRST_TIMER_COUNTER: rd_val = {24'h000000, cnt_r[0]};
			IDX_SECOND_TIMER_COUNTER: rd_val = {24'h000000, cnt_r[1]};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_wait_r) begin
			hrdata_r <= rd_val;
		end
	end

	assign HRDATA = hrdata_r;
	assign HREADYOUT = !rd_wait_r;
	assign HRESP = HRESP_OKAY;

	// ==========================================================
	// control register
	assign per_wr[0] = wr_act_r && (wr_idx_r == IDX_FIRST_TIMER_PERIOD);
	assign per_wr[1] = wr_act_r && (wr_idx_r == IDX_SECOND_TIMER_PERIOD);

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_act_r && (wr_idx_r == IDX_DUAL_TIMER_CONTROL)) begin
			ctrl_nxt = HWDATA[7:0];
			// a written one keeps a flag, a zero clears it; software cannot set one
			ctrl_nxt[FIRST_OVERFLOW_FLAG_BIT] = HWDATA[FIRST_OVERFLOW_FLAG_BIT] && ctrl_r[FIRST_OVERFLOW_FLAG_BIT];
			ctrl_nxt[SECOND_OVERFLOW_FLAG_BIT] = HWDATA[SECOND_OVERFLOW_FLAG_BIT] && ctrl_r[SECOND_OVERFLOW_FLAG_BIT];
		end
		if (ovf_ev[0]) begin
			ctrl_nxt[FIRST_OVERFLOW_FLAG_BIT] = 1'b1;
		end
		if (ovf_ev[1]) begin
			ctrl_nxt[SECOND_OVERFLOW_FLAG_BIT] = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			ctrl_r <= CONTROL_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ==========================================================
	// the two timers
	for (genvar i = 0; i < 2; i++) begin : g_timer
		logic [1:0] sel;
		logic run;
		logic [5:0] term;
		logic tick;

		assign sel = (i == 0) ? ctrl_r[FIRST_CLOCK_SELECT_LO_BIT +: 2] : ctrl_r[SECOND_CLOCK_SELECT_LO_BIT +: 2];
		assign run = (sel != 2'h0);

		always_comb begin
			term = PRESCALE_TERM_SEL1;
			unique case (sel)
				2'h0: term = PRESCALE_TERM_SEL1;
				2'h1: term = PRESCALE_TERM_SEL1;
				2'h2: term = PRESCALE_TERM_SEL2;
				2'h3: term = PRESCALE_TERM_SEL3;
			endcase
		end

		assign tick = run && (pre_r[i] == term);
		// period spans (period+1) count clocks; a period write cancels the event
		assign ovf_ev[i] = tick && (cnt_r[i] == per_r[i]) && !per_wr[i];

		always_ff @(posedge CLK_SYS) begin
			if (SRST) begin
				per_r[i] <= PERIOD_RESET;
			end else if (per_wr[i]) begin
				per_r[i] <= HWDATA[7:0];
			end
		end

		always_ff @(posedge CLK_SYS) begin
			if (SRST || !run || per_wr[i]) begin
				pre_r[i] <= 6'h00;
			end else if (tick) begin
				pre_r[i] <= 6'h00;
			end else begin
				pre_r[i] <= pre_r[i] + 6'h01;
			end
		end

		always_ff @(posedge CLK_SYS) begin
			if (SRST || !run || per_wr[i]) begin
				cnt_r[i] <= 8'h00;
			end else if (tick) begin
				cnt_r[i] <= (cnt_r[i] == per_r[i]) ? 8'h00 : cnt_r[i] + 8'h01;
			end
		end
	end

	// ==========================================================
	// interrupts
	assign VECTOR_REQ = (ctrl_r[FIRST_IRQ_ENABLE_BIT] && ctrl_r[FIRST_OVERFLOW_FLAG_BIT])
		|| (ctrl_r[SECOND_IRQ_ENABLE_BIT] && ctrl_r[SECOND_OVERFLOW_FLAG_BIT]);

	always_comb begin
		evt_nxt = evt_r;
		if (wr_act_r && (wr_idx_r == IDX_EVENT_STATUS)) begin
			evt_nxt = evt_r & ~HWDATA[1:0];
		end
		// set beats a same-cycle write-one clear
		evt_nxt = evt_nxt | ovf_ev;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			evt_r <= EVENT_RESET;
			mask_r <= EVENT_RESET;
		end else begin
			evt_r <= evt_nxt;
			if (wr_act_r && (wr_idx_r == IDX_EVENT_MASK)) begin
				mask_r <= HWDATA[1:0];
			end
		end
	end

	assign IRQ = |(evt_r & mask_r);

endmodule : dual_interval_timer_8bit

// [verif/dual_timer_properties.sv]
// port assertions for the dual interval timer
`timescale 1ns/10ps
module dual_timer_properties
	import dual_timer_pkg::*;
(
	input wire logic CLK_SYS, SRST, HSEL, HWRITE, HREADY, HREADYOUT, VECTOR_REQ, IRQ,
	input wire logic [31:0] HADDR, HRDATA,
	input wire logic [1:0] HTRANS
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	logic tk, wr_r, rd_r, ctl_r;
	assign tk = HSEL && HREADY && HTRANS[1];
	always_ff @(posedge CLK_SYS) begin
		wr_r <= tk && HWRITE && !SRST;
		rd_r <= tk && !HWRITE && !SRST;
		ctl_r <= tk && !HWRITE && !SRST && HADDR == {14'h0, IDX_DUAL_TIMER_CONTROL, 2'h0};
	end
	flag_sticky_a: assert property ($fell(VECTOR_REQ) |-> $past(wr_r) || $past(SRST))
		else $error("vector request dropped");
	event_sticky_a: assert property ($fell(IRQ) |-> $past(wr_r) || $past(SRST))
		else $error("irq dropped");
	vector_match_a: assert property ($past(ctl_r) |-> $past(VECTOR_REQ) ==
		(HRDATA[0] && HRDATA[1] || HRDATA[2] && HRDATA[3])) else $error("vector mismatch");
	read_wait_a: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait wrong");
	write_nowait_a: assert property (tk && HWRITE |=> HREADYOUT)
		else $error("write stalled");
	unmapped_zero_a: assert property (tk && !HWRITE && HADDR[31:18] != 14'h0 |=> ##1 HRDATA == 32'h0)
		else $error("unmapped read nonzero");
	upper_zero_a: assert property ($past(rd_r) |-> HRDATA[31:8] == 24'h0)
		else $error("upper read bits set");
	hrdata_hold_a: assert property ($changed(HRDATA) |-> $past(rd_r) || $past(SRST))
		else $error("read data moved");
endmodule : dual_timer_properties

// [verif/dual_interval_timer_8bit_tb_top.sv]
// self-checking bench for the dual interval timer
`timescale 1ns/10ps
module dual_interval_timer_8bit_tb_top;
	import dual_timer_pkg::*;
	logic clk = 0, srst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, vector_req, irq;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	int fails = 0, samples_checked = 0, cyc = 0;
	always #2 clk = ~clk;
	assign hready = hreadyout;
	dual_interval_timer_8bit i_dual_interval_timer_8bit (.CLK_SYS(clk), .SRST(srst), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .VECTOR_REQ(vector_req), .IRQ(irq));
	task automatic chk(input logic [31:0] g, e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// hsel stays up once used; the slave is alone on the bus
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : xfer
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		logic [31:0] q;
		xfer({14'h0, i, 2'h0}, 1'b1, d, q);
		@(posedge clk);
	endtask : wr
	task automatic rdc(input logic [15:0] i, input logic [31:0] e);
		logic [31:0] q;
		xfer({14'h0, i, 2'h0}, 1'b0, 32'h0, q);
		chk(q, e);
	endtask : rdc
	task automatic bus_edges;
		logic [31:0] q;
		rdc(IDX_DUAL_TIMER_CONTROL, 32'h0);
		rdc(IDX_SECOND_TIMER_PERIOD, 32'h0);
		wr(IDX_DUAL_TIMER_CONTROL, 32'h0f);
		rdc(IDX_DUAL_TIMER_CONTROL, 32'h05);
		xfer({14'h1, IDX_DUAL_TIMER_CONTROL, 2'h0}, 1'b1, 32'hff, q);
		xfer({14'h1, IDX_DUAL_TIMER_CONTROL, 2'h0}, 1'b0, 32'h0, q);
		chk(q, 32'h0);
		chk(hresp, HRESP_OKAY);
		rdc(IDX_DUAL_TIMER_CONTROL, 32'h05);
	endtask : bus_edges
	task automatic run_timer(input int t, input int s);
		int n;
		logic [15:0] p;
		logic [31:0] c;
		p = t ? IDX_SECOND_TIMER_PERIOD : IDX_FIRST_TIMER_PERIOD;
		c = 32'(s << (4 + 2 * t) | 1 << (2 * t));
		wr(p, 32'h3);
		wr(IDX_DUAL_TIMER_CONTROL, c);
		if (s == 3) begin
			repeat (150) @(posedge clk);
			chk(vector_req, 1'b0);
			wr(p, 32'h3);
		end
		n = 1;
		while (vector_req !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk(n >= 4 << 2 * s && n <= (4 << 2 * s) + 2, 1'b1);
		repeat (20) @(posedge clk);
		rdc(IDX_DUAL_TIMER_CONTROL, c | 2 << (2 * t));
		wr(IDX_DUAL_TIMER_CONTROL, 32'h0);
		chk(vector_req, 1'b0);
		rdc(t ? IDX_SECOND_TIMER_COUNTER : IDX_FIRST_TIMER_COUNTER, 32'h0);
	endtask : run_timer
	task automatic irq_path;
		chk(irq, 1'b0);
		rdc(IDX_EVENT_STATUS, 32'h3);
		wr(IDX_EVENT_MASK, 32'h1);
		chk(irq, 1'b1);
		wr(IDX_EVENT_STATUS, 32'h1);
		chk(irq, 1'b0);
		wr(IDX_EVENT_MASK, 32'h2);
		chk(irq, 1'b1);
		wr(IDX_EVENT_STATUS, 32'h2);
		rdc(IDX_EVENT_STATUS, 32'h0);
	endtask : irq_path
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		bus_edges();
		for (int t = 0; t < 2; t++)
			for (int s = 1; s < 4; s++)
				run_timer(t, s);
		irq_path();
		end_of_test();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			end_of_test();
		end
	end
endmodule : dual_interval_timer_8bit_tb_top
bind dual_interval_timer_8bit dual_timer_properties i_dual_timer_properties (.CLK_SYS(CLK_SYS), .SRST(SRST),
	.HSEL(HSEL), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .VECTOR_REQ(VECTOR_REQ),
	.IRQ(IRQ), .HADDR(HADDR), .HRDATA(HRDATA), .HTRANS(HTRANS));
